// >>> verilog/mfrs_status.sv
`timescale 1ns/1ps

module mfrs_status
  import mfrs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire mfrs_cpu_t   cpu_i,
  output mfrs_out_t        cpu_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic        relocation_enable_bit;
    logic        maintenance_destination_mode;
    logic        instruction_complete_flag;
    logic [1:0]  mode;
    logic        space;
    logic [2:0]  page;
    logic [15:0] autoincrement_log;
    logic        first_modification_recorded;
    logic [15:0] instruction_address_log;
    logic        no_error;
    logic        ack;
    logic [31:0] rdata;
    logic [15:0] int_bus_data;
  } mfrs_state_t;

  mfrs_state_t state_reg;
  mfrs_state_t state_next;

  logic [15:0] sr0_word;
  logic [15:0] rd_word;
  logic [1:0]  mode_code;
  logic        relocation_active;
  logic        strobe_ok;
  logic        clear_log;
  logic [3:0]  step_val;
  logic [2:0]  reg_num;
  logic [7:0]  mod_byte;
  logic        bus_req;
  logic        wr_sr0;

  // ----------------------------------------
  // Mode encoding
  // ----------------------------------------
  always_comb
  begin
    case (cpu_i.space)
      MFRS_SP_KERN:  mode_code = MFRS_MODE_KERN;
      MFRS_SP_SUPER: mode_code = MFRS_MODE_SUPER;
      MFRS_SP_USER:  mode_code = MFRS_MODE_USER;
      MFRS_SP_NONE:  mode_code = MFRS_MODE_ILL;
      default:       mode_code = MFRS_MODE_ILL;
    endcase
  end

  // ----------------------------------------
  // Relocation and abort
  // ----------------------------------------
  assign relocation_active =
    (state_reg.relocation_enable_bit & ~cpu_i.console_physical_access)
    | (state_reg.maintenance_destination_mode & cpu_i.final_dest_calc);

  assign strobe_ok = cpu_i.pause_end & relocation_active
                     & ~cpu_i.bus_end_terminate & ~cpu_i.int_reg_access
                     & state_reg.no_error;

  // One driver for the whole output struct
  assign cpu_o = '{relocation_active:   relocation_active,
                   access_abort:        relocation_active
                                        & (mode_code == MFRS_MODE_ILL),
                   access_control_code: (mode_code == MFRS_MODE_ILL)
                                        ? MFRS_ACF_ABORT : 3'h0,
                   int_bus_data:        state_reg.int_bus_data};

  // ----------------------------------------
  // Modification byte
  // ----------------------------------------
  always_comb
  begin
    step_val = cpu_i.mod_dec ? 4'(-cpu_i.step_constant)
                             : cpu_i.step_constant;
    reg_num = cpu_i.general_register_number[2:0];
    if (cpu_i.general_register_number == MFRS_GRA_USP)
    begin
      reg_num[0] = 1'b0;
    end
    mod_byte = {cpu_i.mod_dec, step_val, reg_num};
  end

  assign clear_log = cpu_i.instruction_load_strobe
    | (cpu_i.interrupt_entry_microstate & state_reg.no_error);

  // ----------------------------------------
  // Register views
  // ----------------------------------------
  assign sr0_word = {7'h00,
                     state_reg.maintenance_destination_mode,
                     state_reg.instruction_complete_flag,
                     state_reg.mode,
                     state_reg.space,
                     state_reg.page,
                     state_reg.relocation_enable_bit};

  always_comb
  begin
    case (cpu_i.rd_sel)
      2'h1:    rd_word = state_reg.autoincrement_log;
      2'h2:    rd_word = state_reg.instruction_address_log;
      default: rd_word = sr0_word;
    endcase
  end

  assign bus_req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = bus_req & ~state_reg.ack;
  assign avs_readdata_o = state_reg.rdata;
  assign wr_sr0 = avs_write_i & state_reg.ack
                  & (avs_address_i == MFRS_OFF_SR0);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;

    // Bus handshake: one wait cycle, then answer
    state_next.ack = bus_req & ~state_reg.ack;
    if (avs_read_i & ~state_reg.ack)
    begin
      case (avs_address_i)
        MFRS_OFF_SR0: state_next.rdata = {16'h0000, sr0_word};
        MFRS_OFF_SR1: state_next.rdata = {16'h0000, state_reg.autoincrement_log};
        MFRS_OFF_SR2: state_next.rdata = {16'h0000, state_reg.instruction_address_log};
        default:      state_next.rdata = MFRS_RD_ZERO;
      endcase
    end

    // Software writes reach only the enable and maintenance bits
    if (wr_sr0 & avs_byteenable_i[0])
    begin
      state_next.relocation_enable_bit = avs_writedata_i[MFRS_B_RELOCATION_ACTIVE];
    end
    if (wr_sr0 & avs_byteenable_i[1])
    begin
      state_next.maintenance_destination_mode = avs_writedata_i[MFRS_B_DSTM];
    end

    // No-error state follows the abort flags at pause end
    if (cpu_i.pause_end)
    begin
      state_next.no_error = ~|cpu_i.abort_flags;
    end

    // Instruction complete flag
    if (cpu_i.instruction_load_strobe & state_reg.no_error)
    begin
      state_next.instruction_complete_flag = 1'b0;
    end
    if (cpu_i.interrupt_entry_microstate)
    begin
      state_next.instruction_complete_flag = 1'b1;
    end

    // Reference capture, frozen after an error
    if (strobe_ok)
    begin
      state_next.mode  = mode_code;
      state_next.space = cpu_i.dspace;
      state_next.page  = cpu_i.va[15:13];
    end

    // Autoincrement log; writes never reach it
    if (clear_log)
    begin
      state_next.autoincrement_log = MFRS_RST_WORD;
      state_next.first_modification_recorded = 1'b0;
    end
    if (cpu_i.mod_valid)
    begin
      if (state_next.first_modification_recorded)
      begin
        state_next.autoincrement_log[15:8] = mod_byte;
      end
      else
      begin
        state_next.autoincrement_log[7:0] = mod_byte;
        state_next.first_modification_recorded = 1'b1;
      end
    end

    // Instruction address log; writes never reach it
    if (cpu_i.instruction_load_strobe)
    begin
      state_next.instruction_address_log = cpu_i.va;
    end
    else if (cpu_i.interrupt_entry_microstate)
    begin
      state_next.instruction_address_log = cpu_i.trap_vector;
    end

    // Internal data bus read
    if (cpu_i.rd_en)
    begin
      state_next.int_bus_data = rd_word;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= '0;
      state_reg.no_error <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

endmodule

// >>> verilog/mfrs_pkg.sv
package mfrs_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [3:0] MFRS_OFF_SR0 = 4'h0;
  localparam logic [3:0] MFRS_OFF_SR1 = 4'h4;
  localparam logic [3:0] MFRS_OFF_SR2 = 4'h8;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int MFRS_B_RELOCATION_ACTIVE = 0;
  localparam int MFRS_B_SPACE = 4;
  localparam int MFRS_B_ICOMP = 7;
  localparam int MFRS_B_DSTM  = 8;

  // ----------------------------------------
  // Mode field codes
  // ----------------------------------------
  localparam logic [1:0] MFRS_MODE_KERN  = 2'h0;
  localparam logic [1:0] MFRS_MODE_SUPER = 2'h1;
  localparam logic [1:0] MFRS_MODE_ILL   = 2'h2;
  localparam logic [1:0] MFRS_MODE_USER  = 2'h3;
  localparam logic [2:0] MFRS_ACF_ABORT  = 3'h7;

  // ----------------------------------------
  // Register numbers and reset values
  // ----------------------------------------
  localparam logic [3:0]  MFRS_GRA_USP  = 4'hf;
  localparam logic [15:0] MFRS_RST_WORD = 16'h0000;
  localparam logic [31:0] MFRS_RD_ZERO  = 32'h0000_0000;

  // ----------------------------------------
  // Processor-side inputs and outputs
  // ----------------------------------------
  typedef enum logic [1:0] {
    MFRS_SP_KERN  = 2'b00,
    MFRS_SP_SUPER = 2'b01,
    MFRS_SP_USER  = 2'b10,
    MFRS_SP_NONE  = 2'b11
  } mfrs_space_t;

  typedef struct packed {
    logic        pause_end;
    logic        bus_end_terminate;
    logic        int_reg_access;
    logic [2:0]  abort_flags;
    mfrs_space_t space;
    logic        dspace;
    logic [15:0] va;
    logic        instruction_load_strobe;
    logic        interrupt_entry_microstate;
    logic [15:0] trap_vector;
    logic        mod_valid;
    logic        mod_dec;
    logic [3:0]  general_register_number;
    logic [3:0]  step_constant;
    logic        final_dest_calc;
    logic        console_physical_access;
    logic        rd_en;
    logic [1:0]  rd_sel;
  } mfrs_cpu_t;

  typedef struct packed {
    logic        relocation_active;
    logic        access_abort;
    logic [2:0]  access_control_code;
    logic [15:0] int_bus_data;
  } mfrs_out_t;

endpackage

// >>> sim/mfrs_cpu_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Processor side model
// ----------------------------------------
module mfrs_cpu_model
  import mfrs_pkg::*;
(
  input  logic      clk_i,
  output mfrs_cpu_t cpu_o
);
  mfrs_cpu_t cur = '0;
  assign cpu_o = cur;
  task hold(input mfrs_cpu_t c);
    @(posedge clk_i);
    cur <= c;
  endtask
  // Pulses last exactly one cycle
  task ev(input mfrs_cpu_t c);
    hold(c);
    hold('0);
  endtask
endmodule

// >>> sim/mfrs_status_sva.sv
`timescale 1ns/1ps
module mfrs_status_sva
  import mfrs_pkg::*;
(
  input logic        clk_i,
  input logic        sys_rst_i,
  input logic [3:0]  avs_address_i,
  input logic        avs_read_i,
  input logic        avs_write_i,
  input logic [31:0] avs_writedata_i,
  input logic [3:0]  avs_byteenable_i,
  input logic [31:0] avs_readdata_o,
  input logic        avs_waitrequest_o,
  input mfrs_cpu_t   cpu_i,
  input mfrs_out_t   cpu_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_abort_illegal: assert property (
    cpu_i.space == MFRS_SP_NONE && cpu_o.relocation_active |->
    cpu_o.access_abort && cpu_o.access_control_code == MFRS_ACF_ABORT) else $error("no abort");
  a_console_noreloc: assert property (
    cpu_i.console_physical_access && !cpu_i.final_dest_calc |-> !cpu_o.relocation_active)
    else $error("console relocated");
  a_wait_one: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("wait");
  a_unmapped_zero: assert property (
    avs_read_i && !avs_waitrequest_o && avs_address_i == 4'hc |-> avs_readdata_o == MFRS_RD_ZERO)
    else $error("unmapped data");
  a_readdata_hi: assert property (
    avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:16] == 16'h0) else $error("high half");
  a_log_clear: assert property (
    cpu_i.instruction_load_strobe && !cpu_i.mod_valid ##1 !cpu_i.mod_valid ##1
    cpu_i.rd_en && cpu_i.rd_sel == 2'h1 && !cpu_i.mod_valid |=> cpu_o.int_bus_data == 16'h0)
    else $error("log not cleared");
  a_trap_vector: assert property (
    cpu_i.interrupt_entry_microstate && !cpu_i.instruction_load_strobe ##1
    !cpu_i.interrupt_entry_microstate && !cpu_i.instruction_load_strobe ##1
    cpu_i.rd_en && cpu_i.rd_sel == 2'h2 |=> cpu_o.int_bus_data == $past(cpu_i.trap_vector, 3))
    else $error("trap vector");
  a_icomp_set: assert property (
    cpu_i.interrupt_entry_microstate && !cpu_i.instruction_load_strobe ##1
    !cpu_i.instruction_load_strobe ##1 cpu_i.rd_en && cpu_i.rd_sel == 2'h0
    |=> cpu_o.int_bus_data[MFRS_B_ICOMP]) else $error("complete flag");
  c_capture: cover property (cpu_i.pause_end);
  c_dec: cover property (cpu_i.mod_valid && cpu_i.mod_dec);
  c_write: cover property (avs_write_i && !avs_waitrequest_o);
endmodule
bind mfrs_status mfrs_status_sva u_sva (.*);

// >>> sim/mfrs_status_tb.sv
`timescale 1ns/1ps
module mfrs_status_tb;
  import mfrs_pkg::*;
  localparam logic [1:0] MODE_CODE [3] = '{MFRS_MODE_KERN, MFRS_MODE_SUPER, MFRS_MODE_USER};
  logic        clk_i = 0;
  logic        sys_rst_i = 1;
  logic        rd = 0;
  logic        wr = 0;
  logic        wt;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  mfrs_cpu_t   cpu;
  mfrs_cpu_t   c;
  mfrs_out_t   co;
  int          errors = 0;
  int          n_compared = 0;
  always #2 clk_i = ~clk_i;
  mfrs_cpu_model u_cpu (.clk_i(clk_i), .cpu_o(cpu));
  mfrs_status u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .cpu_i(cpu), .cpu_o(co));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    adr <= a; wr <= w; rd <= !w; wd <= d;
    for (int n = 0; n < 50; n++)
    begin
      @(posedge clk_i);
      if (wt === 1'b0) break;
    end
    q = rdat; rd <= 0; wr <= 0;
  endtask
  task rdi(input logic [1:0] s);
    c = '0; c.rd_en = 1; c.rd_sel = s;
    u_cpu.ev(c);
    @(posedge clk_i);
    q = {16'h0, co.int_bus_data};
  endtask
  task lvl(input mfrs_cpu_t x);
    u_cpu.hold(x);
    @(posedge clk_i);
  endtask
  task ev1(input int kind, input mfrs_space_t s, input logic [2:0] f, input logic b);
    c = '0; c.space = s; c.abort_flags = f; c.bus_end_terminate = b;
    c.pause_end = kind == 0; c.instruction_load_strobe = kind == 1;
    c.interrupt_entry_microstate = kind == 2; c.va = 16'h1234; c.trap_vector = 16'h00f4;
    u_cpu.ev(c);
  endtask
  task md(input logic dec, input logic [3:0] r, input logic [3:0] k);
    c = '0; c.mod_valid = 1; c.mod_dec = dec; c.general_register_number = r; c.step_constant = k;
    u_cpu.ev(c);
  endtask
  task give_verdict;
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task s_regs;
    bus(0, MFRS_OFF_SR0, 32'h0); chk(q[15:0], MFRS_RST_WORD);
    bus(1, MFRS_OFF_SR0, 32'h100);
    c = '0; c.final_dest_calc = 1; lvl(c); chk(co.relocation_active, 16'h1);
    lvl('0); chk(co.relocation_active, 16'h0);
    bus(1, MFRS_OFF_SR0, 32'h1); bus(0, MFRS_OFF_SR0, 32'h0); chk(q[15:0], 16'h1);
    bus(1, MFRS_OFF_SR1, 32'hffff); bus(0, MFRS_OFF_SR1, 32'h0); chk(q[15:0], 16'h0);
    bus(1, MFRS_OFF_SR2, 32'hffff); bus(0, MFRS_OFF_SR2, 32'h0); chk(q[15:0], 16'h0);
    bus(0, 4'hc, 32'h0); chk(q[15:0], 16'h0);
    c = '0; c.console_physical_access = 1; lvl(c); chk(co.relocation_active, 16'h0);
    c = '0; c.space = MFRS_SP_NONE; lvl(c); chk({co.access_abort, co.access_control_code}, 16'hf);
    u_cpu.hold('0);
  endtask
  task s_cap;
    for (int i = 0; i < 3; i++)
    begin
      c = '0; c.pause_end = 1; c.space = mfrs_space_t'(i); c.dspace = i[0]; c.va = 16'(i + 5) << 13;
      u_cpu.ev(c);
      bus(0, MFRS_OFF_SR0, 32'h0); chk(q[15:0], {MODE_CODE[i], i[0], 3'(i + 5), 1'b1});
    end
    ev1(2, MFRS_SP_KERN, 3'h0, 0); rdi(2'h0); chk(q[15:0], 16'hef);
    ev1(0, MFRS_SP_KERN, 3'h1, 0); ev1(1, MFRS_SP_KERN, 3'h0, 0);
    ev1(0, MFRS_SP_USER, 3'h0, 0);
    bus(0, MFRS_OFF_SR0, 32'h0); chk(q[15:0], 16'h81);
    ev1(1, MFRS_SP_KERN, 3'h0, 0); ev1(0, MFRS_SP_USER, 3'h0, 1);
    bus(0, MFRS_OFF_SR0, 32'h0); chk(q[15:0], 16'h1);
  endtask
  task s_log;
    md(0, 4'h5, 4'h2); md(1, MFRS_GRA_USP, 4'h1);
    rdi(2'h1); chk(q[15:0], 16'hfe15);
    md(0, 4'h3, 4'h8);
    ev1(1, MFRS_SP_KERN, 3'h0, 0); rdi(2'h1); chk(q[15:0], 16'h0);
    bus(0, MFRS_OFF_SR2, 32'h0); chk(q[15:0], 16'h1234);
    md(1, 4'h3, 4'h8);
    ev1(2, MFRS_SP_KERN, 3'h0, 0); rdi(2'h2); chk(q[15:0], 16'h00f4);
    md(1, 4'h6, 4'h2); rdi(2'h1); chk(q[15:0], 16'h00f6);
  endtask
  initial
  begin
    #40000;
    errors++;
    give_verdict;
  end
  initial
  begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 0;
    s_regs;
    s_cap;
    s_log;
    give_verdict;
  end
endmodule
